// ---- rtl/cpg_pkg.sv ----
// Package with register map, field layout and timing constants of the clock pulse generator
package cpg_pkg;
	localparam logic [11:0] OFF_WAIT_CLK_CTRL = 12'h000;
	localparam logic [11:0] OFF_TAP_STATUS = 12'h004;
	localparam logic [7:0] WCC_RESET = 8'hc8;
	localparam logic [7:0] WCC_FIXED_ONES = 8'hc0;
	localparam int HALVE_BIT = 5;
	localparam int RSVD_BIT = 4;
	localparam int WMODE_LSB = 2;
	localparam int WCOUNT_LSB = 0;
	localparam int PRESCALE_BITS = 12;
	localparam int SYNC_STAGES = 2;
	localparam int CLK_MHZ = 100;
	localparam int DUTY_THRESH_MHZ = 5;
	localparam int SETTLE_US = 500;
	localparam int SETTLE_CYCLES = SETTLE_US * CLK_MHZ;
	localparam int RESET_MIN_CYCLES = 10;
	typedef enum logic [1:0] {
		CPG_WAIT_PROG = 2'b00,
		CPG_WAIT_NONE = 2'b01,
		CPG_WAIT_PIN = 2'b10,
		CPG_WAIT_AUTO = 2'b11
	} cpg_wait_mode_t;
endpackage : cpg_pkg

// ---- rtl/cpg_tap_if.sv ----
// Interface carrying the peripheral clock enable and prescaler taps
`timescale 1ns/10ps
`default_nettype none
interface cpg_tap_if;
	logic halve;
	logic periph_en;
	logic [11:0] taps;
	logic [11:0] count;
	modport gen (input halve, output periph_en, output taps, output count);
	modport use_side (output halve, input periph_en, input taps, input count);
endinterface : cpg_tap_if
`default_nettype wire

// ---- rtl/cpg_prescaler.sv ----
// Peripheral clock enable and prescaler tap generator
`timescale 1ns/10ps
`default_nettype none
module cpg_prescaler (
	input wire logic mclk,
	input wire logic rst_n,
	cpg_tap_if.gen tap
);
	typedef struct packed {
		logic phase;
		logic [11:0] count;
		logic [11:0] taps;
	} cpg_pre_state_t;
	cpg_pre_state_t st_reg;
	cpg_pre_state_t st_next;
	logic pen;
	logic [11:0] cnt_inc;

	// Mask of the low k+1 counter bits that gate tap k
	function automatic logic [11:0] tap_mask(input int k);
		tap_mask = 12'hfff >> (11 - k);
	endfunction : tap_mask

	// Halving gives an enable every other system cycle
	assign pen = tap.halve ? st_reg.phase : 1'b1;
	assign cnt_inc = st_reg.count + 12'h001;

	always_comb begin
		st_next = st_reg;
		st_next.phase = ~st_reg.phase;
		st_next.taps = 12'h000;
		if (pen) begin
			// One shared counter keeps every tap phase-locked
			st_next.count = cnt_inc;
			// Tap k pulses once per 2^(k+1) peripheral cycles
			for (int k = 0; k < 12; k++) begin
				st_next.taps[k] = ((st_reg.count & tap_mask(k)) == tap_mask(k));
			end
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign tap.periph_en = pen;
	assign tap.taps = st_reg.taps;
	assign tap.count = st_reg.count;
endmodule : cpg_prescaler
`default_nettype wire

// ---- rtl/cpg_clock_gen.sv ----
// Clock pulse generator top with AHB-Lite register slave
//
// Our own choices: the AHB-Lite register port and the register addresses.
`timescale 1ns/10ps
`default_nettype none
// Functional notes
// - System clock equals input clock frequency, no multiplication.
// - Halve bit zero feeds undivided system clock to peripherals; reset state.
// - Halve bit one feeds system clock divided by two to peripherals.
// - Control register loads 0xc8 on reset and hardware standby; kept in software standby.
// - Bits 7 and 6 always read one; writes ignored.
// - Bit 4 is plain read/write storage, resets to zero.
// - Prescaler gives taps from peripheral clock /2 down to /4096.
// - Duty correction applies when clock is 5 MHz or above.
// - Wait mode field decodes programmable, none, pin, pin auto; resets to pin.
// - Wait count field selects zero to three wait states; resets zero.
module cpg_clock_gen (
	input wire logic mclk,
	input wire logic rstn,
	input wire logic hw_standby,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	output logic periph_clk_en,
	output logic [11:0] prescale_taps,
	output logic duty_adjust_on,
	output logic [1:0] wait_mode,
	output logic [1:0] wait_states
);
	typedef enum logic [1:0] {
		CPG_BUS_IDLE = 2'b00,
		CPG_BUS_WRITE = 2'b01,
		CPG_BUS_READ = 2'b10
	} cpg_bus_phase_t;
	typedef enum logic [1:0] {
		CPG_SEL_CTRL = 2'b00,
		CPG_SEL_STATUS = 2'b01,
		CPG_SEL_NONE = 2'b10
	} cpg_reg_sel_t;
	typedef struct packed {
		logic [7:0] wcc;
		cpg_bus_phase_t phase;
		cpg_reg_sel_t sel;
		logic [31:0] rdata;
	} cpg_top_state_t;
	cpg_top_state_t st_reg;
	cpg_top_state_t st_next;
	logic [1:0] rst_sync_reg;
	logic rst_n;
	logic addr_phase;
	cpg_reg_sel_t addr_sel;
	cpg_tap_if tap ();

	// Two-stage release of the asynchronous reset
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			rst_sync_reg <= 2'b00;
		end else begin
			rst_sync_reg <= {rst_sync_reg[0], 1'b1};
		end
	end
	assign rst_n = rst_sync_reg[1];

	function automatic logic [7:0] wcc_read(input logic [7:0] v);
		wcc_read = v | cpg_pkg::WCC_FIXED_ONES;
	endfunction : wcc_read

	// Only the low address bits decode, so the map repeats every 4 KB
	function automatic cpg_reg_sel_t reg_decode(input logic [11:0] a);
		case (a)
			cpg_pkg::OFF_WAIT_CLK_CTRL: begin
				reg_decode = CPG_SEL_CTRL;
			end
			cpg_pkg::OFF_TAP_STATUS: begin
				reg_decode = CPG_SEL_STATUS;
			end
			default: begin
				reg_decode = CPG_SEL_NONE;
			end
		endcase
	endfunction : reg_decode

	function automatic logic [31:0] status_word(input logic halve, input logic [11:0] count);
		status_word = 32'h0000_0000;
		status_word[27:16] = count;
		status_word[0] = halve;
	endfunction : status_word

	function automatic cpg_pkg::cpg_wait_mode_t wait_mode_of(input logic [7:0] v);
		case (v[cpg_pkg::WMODE_LSB +: 2])
			2'h0: begin
				wait_mode_of = cpg_pkg::CPG_WAIT_PROG;
			end
			2'h1: begin
				wait_mode_of = cpg_pkg::CPG_WAIT_NONE;
			end
			2'h2: begin
				wait_mode_of = cpg_pkg::CPG_WAIT_PIN;
			end
			default: begin
				wait_mode_of = cpg_pkg::CPG_WAIT_AUTO;
			end
		endcase
	endfunction : wait_mode_of

	assign addr_phase = hsel & hready & htrans[1];
	assign addr_sel = reg_decode(haddr[11:0]);

	always_comb begin
		st_next = st_reg;
		// Data phase of the transfer taken at the last edge
		case (st_reg.phase)
			CPG_BUS_WRITE: begin
				if (st_reg.sel == CPG_SEL_CTRL) begin
					// Top bits stay one; bit 4 stores freely
					st_next.wcc = wcc_read(hwdata[7:0]);
				end
			end
			CPG_BUS_READ: begin
				st_next.rdata = st_reg.rdata;
			end
			CPG_BUS_IDLE: begin
				st_next.rdata = st_reg.rdata;
			end
			default: begin
				st_next.sel = CPG_SEL_NONE;
			end
		endcase
		st_next.phase = CPG_BUS_IDLE;
		if (addr_phase) begin
			st_next.sel = addr_sel;
			if (hwrite) begin
				st_next.phase = CPG_BUS_WRITE;
			end else begin
				st_next.phase = CPG_BUS_READ;
				// Registered now so it stands through the whole data phase
				case (addr_sel)
					CPG_SEL_CTRL: begin
						// Sees a write landing in this same cycle
						st_next.rdata = {24'h000000, wcc_read(st_next.wcc)};
					end
					CPG_SEL_STATUS: begin
						st_next.rdata = status_word(st_next.wcc[cpg_pkg::HALVE_BIT], tap.count);
					end
					default: begin
						st_next.rdata = 32'h0000_0000;
					end
				endcase
			end
		end
		// Hardware standby reloads, software standby is not seen here
		if (hw_standby) begin
			st_next.wcc = cpg_pkg::WCC_RESET;
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			st_reg.wcc <= cpg_pkg::WCC_RESET;
			st_reg.phase <= CPG_BUS_IDLE;
			st_reg.sel <= CPG_SEL_NONE;
			st_reg.rdata <= 32'h0000_0000;
		end else begin
			st_reg <= st_next;
		end
	end

	assign tap.halve = st_reg.wcc[cpg_pkg::HALVE_BIT];

	cpg_prescaler u_pre (
		.mclk(mclk),
		.rst_n(rst_n),
		.tap(tap)
	);

	// Register slave answers with zero wait states, always OKAY
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = st_reg.rdata;
	// System clock is mclk itself; no multiplier exists
	assign periph_clk_en = tap.periph_en;
	assign prescale_taps = tap.taps;
	// Fixed clock is far above threshold, so correction stays on
	assign duty_adjust_on = (cpg_pkg::CLK_MHZ >= cpg_pkg::DUTY_THRESH_MHZ);
	assign wait_mode = wait_mode_of(st_reg.wcc);
	assign wait_states = st_reg.wcc[cpg_pkg::WCOUNT_LSB +: 2];
endmodule : cpg_clock_gen
`default_nettype wire

// ---- verif/cpg_crystal_output_src.sv ----
// Crystal or external clock source model driving the system clock
`timescale 1ns/10ps
`default_nettype none
module cpg_crystal_output_src (
	output logic mclk
);
	initial mclk = 1'b0;
	// Source runs free; the device passes it on undivided
	always #5 mclk = ~mclk;
endmodule : cpg_crystal_output_src
`default_nettype wire

// ---- verif/cpg_assertions.sv ----
// Port checks for the clock pulse generator
`timescale 1ns/10ps
`default_nettype none
module cpg_assertions (
	input wire logic mclk,
	input wire logic rstn,
	input wire logic hw_standby,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic periph_clk_en,
	input wire logic [11:0] prescale_taps,
	input wire logic duty_adjust_on,
	input wire logic [1:0] wait_mode,
	input wire logic [1:0] wait_states
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!rstn);
	a_duty_on: assert property (duty_adjust_on) else $error("duty off");
	a_bus_okay: assert property (hreadyout && !hresp) else $error("bus stall");
	a_en_alt: assert property (!periph_clk_en |=> periph_clk_en) else $error("en gap");
	a_stby_load: assert property (hw_standby |=> wait_mode == 2'b10 && wait_states == 2'b00)
		else $error("standby reload");
	a_tap0_pulse: assert property (prescale_taps[0] |=> !prescale_taps[0]) else $error("tap0");
	a_tap1_gap: assert property (prescale_taps[1] |=> !prescale_taps[1] [*3]) else $error("tap1");
	a_tap_nest: assert property ((prescale_taps[11:1] & ~prescale_taps[10:0]) == 11'h000)
		else $error("tap phase");
	a_tap0_rate: assert property (prescale_taps[0] |-> ##[2:4] prescale_taps[0])
		else $error("tap0 rate");
endmodule : cpg_assertions
`default_nettype wire

// ---- verif/cpg_clock_gen_test.sv ----
// Self-checking bench for the clock pulse generator
`timescale 1ns/10ps
`default_nettype none
module cpg_clock_gen_test;
	localparam logic [11:0] W = cpg_pkg::OFF_WAIT_CLK_CTRL;
	wire mclk;
	logic rstn, hw_standby, hsel, hwrite, hreadyout, hresp, periph_clk_en, duty_adjust_on;
	logic [31:0] haddr, hwdata, hrdata;
	logic [1:0] htrans, wait_mode, wait_states;
	logic [11:0] prescale_taps;
	logic [2:0] hsize = 3'b010;
	wire hready = hreadyout;
	int err_total = 0, n_tests = 0, n;
	cpg_crystal_output_src crystal_output (.mclk(mclk));
	cpg_clock_gen dut (
		.mclk(mclk),
		.rstn(rstn),
		.hw_standby(hw_standby),
		.hsel(hsel),
		.haddr(haddr),
		.htrans(htrans),
		.hwrite(hwrite),
		.hsize(hsize),
		.hwdata(hwdata),
		.hready(hready),
		.hrdata(hrdata),
		.hreadyout(hreadyout),
		.hresp(hresp),
		.periph_clk_en(periph_clk_en),
		.prescale_taps(prescale_taps),
		.duty_adjust_on(duty_adjust_on),
		.wait_mode(wait_mode),
		.wait_states(wait_states)
	);
	task automatic chk(input string s, input logic [31:0] e, v);
		n_tests++;
		if (v !== e) begin
			err_total++;
			$display("ERROR %s expected %h seen %h", s, e, v);
		end
	endtask : chk
	task automatic end_of_test(input int hung);
		err_total += hung;
		$display("checks %0d errors %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : end_of_test
	task automatic ready;
		int i;
		i = 0;
		do begin
			@(posedge mclk);
			if (++i > 50) end_of_test(1);
		end while (hready !== 1'b1);
	endtask : ready
	// Called just after an edge; read data is compared to d
	task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		htrans <= 2'b10;
		haddr <= {20'h00000, a};
		hwrite <= w;
		ready;
		htrans <= 2'b00;
		hwdata <= d;
		ready;
		if (!w) chk("hrdata", d, hrdata);
	endtask : bus
	task automatic cnt(input int e);
		n = 0;
		repeat (8) begin
			@(posedge mclk);
			n += (periph_clk_en === 1'b1);
		end
		chk("periph_clk_en count", e, n);
	endtask : cnt
	task automatic t_fields;
		bus(1'b0, W, 32'h000000c8);
		bus(1'b0, 12'h010, 32'h00000000);
		bus(1'b1, W, 32'h00000000);
		bus(1'b0, W, 32'h000000c0);
		bus(1'b1, W, 32'h0000003f);
		bus(1'b0, W, 32'h000000ff);
		for (int m = 0; m < 4; m++) begin
			bus(1'b1, W, {28'h0, 2'(m), 2'(m)});
			// Register settles at the data phase edge; look one edge later
			@(posedge mclk);
			chk("wait_mode", m, {30'h0, wait_mode});
			chk("wait_states", m, {30'h0, wait_states});
		end
	endtask : t_fields
	task automatic t_halve;
		bus(1'b1, W, 32'h00000020);
		cnt(4);
		bus(1'b1, W, 32'h00000000);
		cnt(8);
	endtask : t_halve
	task automatic t_stby;
		bus(1'b1, W, 32'h00000035);
		bus(1'b0, W, 32'h000000f5);
		hw_standby <= 1'b1;
		@(posedge mclk);
		hw_standby <= 1'b0;
		bus(1'b0, W, 32'h000000c8);
	endtask : t_stby
	// Slowest tap: one pulse every 4096 cycles with the full-rate clock
	task automatic t_tap;
		repeat (2) begin
			n = 0;
			do begin
				@(posedge mclk);
				n++;
			end while (prescale_taps[11] !== 1'b1 && n < 9000);
			if (n >= 9000) end_of_test(1);
		end
		chk("tap11 period", 4096, n);
	endtask : t_tap
	initial begin
		{rstn, hw_standby, hsel, hwrite, haddr, hwdata, htrans} = '0;
		// Model clock is clean from time zero, so no settle wait is needed
		repeat (6) @(posedge mclk);
		rstn <= 1'b1;
		repeat (3) @(posedge mclk);
		t_fields;
		t_halve;
		t_stby;
		t_tap;
		end_of_test(0);
	end
endmodule : cpg_clock_gen_test
bind cpg_clock_gen cpg_assertions chk_i (
	.mclk(mclk),
	.rstn(rstn),
	.hw_standby(hw_standby),
	.hreadyout(hreadyout),
	.hresp(hresp),
	.periph_clk_en(periph_clk_en),
	.prescale_taps(prescale_taps),
	.duty_adjust_on(duty_adjust_on),
	.wait_mode(wait_mode),
	.wait_states(wait_states)
);
`default_nettype wire
